// ==== common/nsl_params.svh ====
`ifndef NSL_PARAMS_SVH
`define NSL_PARAMS_SVH

// ****************************************
// clock and flash timing
// ****************************************
`define NSL_CLK_MHZ 100
`define NSL_FLASH_HALF_MS 500
`define NSL_FLASH_HALF_CYC (`NSL_FLASH_HALF_MS * 1000 * `NSL_CLK_MHZ)

// ****************************************
// widths and counts
// ****************************************
`define NSL_ASYNC_W 3
`define NSL_SERIAL_PORTS 2
`define NSL_TMO_CNT_W 8
`define NSL_TMO_CNT_MAX 8'hFF
`define NSL_TMO_CNT_ZERO 8'h00
`define NSL_TMO_CNT_ONE 8'h01
`define NSL_IP_W 32
`define NSL_IP_RESET 32'h0000_0000

// ****************************************
// lamp bus positions, front lamp in the top pair
// ****************************************
`define NSL_BUS_NET_HI 7
`define NSL_BUS_NET_LO 6
`define NSL_BUS_UNIT_HI 5
`define NSL_BUS_UNIT_LO 4
`define NSL_BUS_ACT_HI 3
`define NSL_BUS_ACT_LO 2
`define NSL_BUS_LINK_HI 1
`define NSL_BUS_LINK_LO 0

`endif

// ==== common/nsl_pkg.sv ====
package nsl_pkg;

   // ****************************************
   // lamp colours
   // ****************************************
   typedef enum logic [1:0] {
      NSL_OFF = 2'b00,
      NSL_GREEN = 2'b01,
      NSL_RED = 2'b10
   } nsl_color_type;

   // ****************************************
   // lamp indications
   // ****************************************
   typedef enum logic [2:0] {
      NSL_NET_DARK = 3'b000,
      NSL_NET_IDLE = 3'b001,
      NSL_NET_CONN = 3'b010,
      NSL_NET_TMO = 3'b011,
      NSL_NET_DUP = 3'b100,
      NSL_NET_TEST = 3'b101,
      NSL_NET_UNUSED = 3'b110
   } nsl_net_state_type;

   typedef enum logic [2:0] {
      NSL_UNIT_UNUSED = 3'b000,
      NSL_UNIT_TEST = 3'b001,
      NSL_UNIT_MAJOR = 3'b010,
      NSL_UNIT_MINOR = 3'b011,
      NSL_UNIT_STBY = 3'b100,
      NSL_UNIT_OK = 3'b101
   } nsl_unit_state_type;

   typedef enum logic {
      NSL_PROTO_RTU = 1'b0,
      NSL_PROTO_SBUS = 1'b1
   } nsl_proto_type;

endpackage

// ==== common/nsl_flash_if.sv ====
`timescale 1ns/1ps
interface nsl_flash_if;
   logic phase;
   logic half_tick;
   modport timer (output phase, output half_tick);
   modport user (input phase, input half_tick);
endinterface

// ==== verilog/nsl_blink_timer.sv ====
`timescale 1ns/1ps
`include "nsl_params.svh"
module nsl_blink_timer #(
   parameter int unsigned HALF_CYC = `NSL_FLASH_HALF_CYC
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   nsl_flash_if.timer flash_out
);
   import nsl_pkg::*;

   localparam int CW = $clog2(HALF_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);
   localparam logic [CW-1:0] ZERO = '0;

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic phase_reg;
   wire logic wrap_w = (cnt_reg == LAST);

   // ****************************************
   // half period counter
   // ****************************************
   // equal halves, colour swap on every wrap
   assign cnt_next = wrap_w ? ZERO : cnt_reg + CW'(1); // R19
   assign flash_out.half_tick = wrap_w;
   assign flash_out.phase = phase_reg;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_reg <= '0;
         phase_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         phase_reg <= phase_reg ^ wrap_w; // R19
      end
   end

   // ****************************************
   // checks
   // ****************************************
   property p_phase_only_on_wrap;
      @(posedge clk_in) disable iff (!rst_n_in)
      (phase_reg != $past(phase_reg)) |-> $past(wrap_w);
   endproperty
   a_phase_only_on_wrap: assert property (p_phase_only_on_wrap) else $error("phase moved off wrap"); // R19

   property p_wrap_flips;
      @(posedge clk_in) disable iff (!rst_n_in)
      wrap_w |=> (phase_reg != $past(phase_reg)) && (cnt_reg == ZERO);
   endproperty
   a_wrap_flips: assert property (p_wrap_flips) else $error("wrap without phase flip"); // R19

endmodule // nsl_blink_timer

// ==== verilog/nsl_sync.sv ====
`timescale 1ns/1ps
module nsl_sync #(
   parameter int W = 3
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   import nsl_pkg::*;

   // ****************************************
   // three flop synchroniser per bit
   // ****************************************
   // a change is taken only when stages two and three agree,
   // so a single metastable sample never reaches the lamps
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         logic q_reg;
         wire logic agree_w = (s2_reg == s3_reg);
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
               s3_reg <= 1'b0;
               q_reg <= 1'b0;
            end else begin
               s1_reg <= d_in[i];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (agree_w) begin
                  q_reg <= s3_reg;
               end
            end
         end
         assign q_out[i] = q_reg;
      end
   endgenerate

endmodule // nsl_sync

// ==== verilog/nsl_status_led.sv ====
// Function
// [R1] four lamps ordered net, unit, activity, link
// [R2] no address: network lamp dark
// [R3] address, no connection: network flashes green
// [R4] any connection: network steady green
// [R5] targeted connection timeout: network flashes red
// [R6] timeout sticky until all re-established
// [R7] duplicate address: network steady red
// [R8] self-test: both lamps alternate green/red
// [R9] operating correctly: unit steady green
// [R10] unconfigured standby: unit flashes green
// [R11] minor fault: unit flashes red
// [R12] bad configuration counts as minor fault
// [R13] major fault: unit steady red
// [R14] tcp mode: network and unit lamps unused
// [R15] one protocol per serial port
// [R16] fixed address applies after power cycle
// [R17] activity flashes green, collision red
// [R18] link lamp dark until link, then green
// [R19] equal flash halves, alternation without dark
// [R20] network lamp priority order
// [R21] unit lamp priority order
`timescale 1ns/1ps
`include "nsl_params.svh"
module nsl_status_led #(
   parameter int unsigned HALF_CYC = `NSL_FLASH_HALF_CYC
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic selftest_in,
   input wire logic modbus_tcp_in,
   input wire logic ip_held_in,
   input wire logic conn_open_in,
   input wire logic conn_timeout_in,
   input wire logic conn_reestab_in,
   input wire logic dup_ip_in,
   input wire logic unconfigured_in,
   input wire logic minor_fault_in,
   input wire logic config_bad_in,
   input wire logic major_fault_in,
   input wire logic mac_activity_in,
   input wire logic mac_collision_in,
   input wire logic phy_link_in,
   input wire logic [`NSL_SERIAL_PORTS-1:0] port_proto_in,
   output logic [`NSL_SERIAL_PORTS-1:0] rtu_en_out,
   output logic [`NSL_SERIAL_PORTS-1:0] sbus_en_out,
   input wire logic [`NSL_IP_W-1:0] nv_ip_in,
   input wire logic ip_wr_in,
   input wire logic [`NSL_IP_W-1:0] ip_wr_data_in,
   output logic nv_ip_wr_out,
   output logic [`NSL_IP_W-1:0] nv_ip_data_out,
   output logic [`NSL_IP_W-1:0] active_ip_out,
   output logic ip_change_pending_out,
   output nsl_pkg::nsl_color_type net_led_out,
   output nsl_pkg::nsl_color_type unit_led_out,
   output nsl_pkg::nsl_color_type act_led_out,
   output nsl_pkg::nsl_color_type link_led_out,
   output logic [7:0] lamp_bus_out
);
   import nsl_pkg::*;

   // ****************************************
   // flash timing and synchronisers
   // ****************************************
   nsl_flash_if flash ();

   nsl_blink_timer #(
      .HALF_CYC(HALF_CYC)
   ) u_timer (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .flash_out(flash)
   );

   // mac and phy signals live outside this clock
   logic [`NSL_ASYNC_W-1:0] async_q;

   nsl_sync #(
      .W(`NSL_ASYNC_W)
   ) u_sync (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .d_in({phy_link_in, mac_collision_in, mac_activity_in}),
      .q_out(async_q)
   );

   wire logic act_w = async_q[0];
   wire logic coll_w = async_q[1];
   wire logic link_w = async_q[2];
   wire logic phase_w = flash.phase;

   // ****************************************
   // sticky timeout tally
   // ****************************************
   // counts timed-out target connections; a timeout and a
   // re-establish in one cycle cancel, at zero the timeout wins and at 8'hFF the re-establish wins
   logic [`NSL_TMO_CNT_W-1:0] tmo_cnt_reg;
   logic [`NSL_TMO_CNT_W-1:0] tmo_cnt_next;
   wire logic tmo_inc_w = conn_timeout_in && (tmo_cnt_reg != `NSL_TMO_CNT_MAX);
   wire logic tmo_dec_w = conn_reestab_in && (tmo_cnt_reg != `NSL_TMO_CNT_ZERO);
   wire logic tmo_act_w = (tmo_cnt_reg != `NSL_TMO_CNT_ZERO);

   assign tmo_cnt_next = (tmo_inc_w && !tmo_dec_w) ? tmo_cnt_reg + `NSL_TMO_CNT_ONE :
                         (tmo_dec_w && !tmo_inc_w) ? tmo_cnt_reg - `NSL_TMO_CNT_ONE :
                         tmo_cnt_reg; // R6

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tmo_cnt_reg <= `NSL_TMO_CNT_ZERO;
      end else begin
         tmo_cnt_reg <= tmo_cnt_next; // R6
      end
   end

   // ****************************************
   // indication selection
   // ****************************************
   nsl_net_state_type net_state_w;
   nsl_unit_state_type unit_state_w;
   wire logic minor_w = minor_fault_in || config_bad_in; // R12

   assign net_state_w = modbus_tcp_in ? NSL_NET_UNUSED : // R14
                        selftest_in ? NSL_NET_TEST : // R20
                        dup_ip_in ? NSL_NET_DUP :
                        tmo_act_w ? NSL_NET_TMO :
                        conn_open_in ? NSL_NET_CONN :
                        ip_held_in ? NSL_NET_IDLE :
                        NSL_NET_DARK;

   assign unit_state_w = modbus_tcp_in ? NSL_UNIT_UNUSED : // R14
                         selftest_in ? NSL_UNIT_TEST : // R21
                         major_fault_in ? NSL_UNIT_MAJOR :
                         minor_w ? NSL_UNIT_MINOR :
                         unconfigured_in ? NSL_UNIT_STBY :
                         NSL_UNIT_OK;

   // flash halves come from one shared phase
   wire nsl_color_type flash_grn_w = phase_w ? NSL_GREEN : NSL_OFF; // R19
   wire nsl_color_type flash_red_w = phase_w ? NSL_RED : NSL_OFF;
   wire nsl_color_type alt_w = phase_w ? NSL_GREEN : NSL_RED; // R19

   nsl_color_type net_next;
   nsl_color_type unit_next;
   nsl_color_type act_next;
   nsl_color_type link_next;

   always_comb begin
      case (net_state_w)
         NSL_NET_IDLE: net_next = flash_grn_w; // R3
         NSL_NET_CONN: net_next = NSL_GREEN; // R4
         NSL_NET_TMO: net_next = flash_red_w; // R5
         NSL_NET_DUP: net_next = NSL_RED; // R7
         NSL_NET_TEST: net_next = alt_w; // R8
         default: net_next = NSL_OFF; // R2
      endcase
   end

   always_comb begin
      case (unit_state_w)
         NSL_UNIT_TEST: unit_next = alt_w; // R8
         NSL_UNIT_MAJOR: unit_next = NSL_RED; // R13
         NSL_UNIT_MINOR: unit_next = flash_red_w; // R11
         NSL_UNIT_STBY: unit_next = flash_grn_w; // R10
         NSL_UNIT_OK: unit_next = NSL_GREEN; // R9
         default: unit_next = NSL_OFF;
      endcase
   end

   // collision outranks activity so it is never masked
   assign act_next = coll_w ? NSL_RED : act_w ? flash_grn_w : NSL_OFF; // R17
   assign link_next = link_w ? NSL_GREEN : NSL_OFF; // R18

   // ****************************************
   // lamp registers
   // ****************************************
   nsl_color_type net_reg;
   nsl_color_type unit_reg;
   nsl_color_type act_reg;
   nsl_color_type link_reg;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         net_reg <= NSL_OFF;
         unit_reg <= NSL_OFF;
         act_reg <= NSL_OFF;
         link_reg <= NSL_OFF;
      end else begin
         net_reg <= net_next;
         unit_reg <= unit_next;
         act_reg <= act_next;
         link_reg <= link_next;
      end
   end

   assign net_led_out = net_reg;
   assign unit_led_out = unit_reg;
   assign act_led_out = act_reg;
   assign link_led_out = link_reg;
   assign lamp_bus_out = {net_reg, unit_reg, act_reg, link_reg}; // R1

   // ****************************************
   // serial port protocol steering
   // ****************************************
   genvar p;
   generate
      for (p = 0; p < `NSL_SERIAL_PORTS; p++) begin : g_port
         logic rtu_reg;
         logic sbus_reg;
         wire logic sel_sbus_w = (port_proto_in[p] == NSL_PROTO_SBUS);
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               rtu_reg <= 1'b0;
               sbus_reg <= 1'b0;
            end else begin
               rtu_reg <= !sel_sbus_w; // R15
               sbus_reg <= sel_sbus_w; // R15
            end
         end
         assign rtu_en_out[p] = rtu_reg;
         assign sbus_en_out[p] = sbus_reg;
      end
   endgenerate

   // ****************************************
   // fixed address handling
   // ****************************************
   // the stored address is adopted once after reset release only;
   // writes go to storage and wait for the next power cycle
   logic ip_loaded_reg;
   logic [`NSL_IP_W-1:0] active_ip_reg;
   logic nv_wr_reg;
   logic [`NSL_IP_W-1:0] nv_data_reg;
   logic pending_reg;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ip_loaded_reg <= 1'b0;
         active_ip_reg <= `NSL_IP_RESET;
         nv_wr_reg <= 1'b0;
         nv_data_reg <= `NSL_IP_RESET;
         pending_reg <= 1'b0;
      end else begin
         ip_loaded_reg <= 1'b1;
         if (!ip_loaded_reg) begin
            active_ip_reg <= nv_ip_in; // R16
         end
         nv_wr_reg <= ip_wr_in;
         if (ip_wr_in) begin
            nv_data_reg <= ip_wr_data_in;
         end
         pending_reg <= pending_reg || ip_wr_in; // R16
      end
   end

   assign active_ip_out = active_ip_reg;
   assign nv_ip_wr_out = nv_wr_reg;
   assign nv_ip_data_out = nv_data_reg;
   assign ip_change_pending_out = pending_reg;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   wire logic net_quiet_w = !modbus_tcp_in && !selftest_in && !dup_ip_in && !tmo_act_w;

   property p_order;
      lamp_bus_out[`NSL_BUS_NET_HI:`NSL_BUS_NET_LO] == net_led_out &&
      lamp_bus_out[`NSL_BUS_UNIT_HI:`NSL_BUS_UNIT_LO] == unit_led_out &&
      lamp_bus_out[`NSL_BUS_ACT_HI:`NSL_BUS_ACT_LO] == act_led_out &&
      lamp_bus_out[`NSL_BUS_LINK_HI:`NSL_BUS_LINK_LO] == link_led_out;
   endproperty
   a_order: assert property (p_order) else $error("lamp order wrong"); // R1

   property p_no_ip;
      net_quiet_w && !conn_open_in && !ip_held_in |=> net_led_out == NSL_OFF;
   endproperty
   a_no_ip: assert property (p_no_ip) else $error("network lamp lit without address"); // R2

   property p_idle;
      net_quiet_w && !conn_open_in && ip_held_in |=> net_led_out == ($past(phase_w) ? NSL_GREEN : NSL_OFF);
   endproperty
   a_idle: assert property (p_idle) else $error("idle not flashing green"); // R3

   property p_conn;
      net_quiet_w && conn_open_in |=> net_led_out == NSL_GREEN;
   endproperty
   a_conn: assert property (p_conn) else $error("connected not steady green"); // R4

   property p_tmo;
      conn_timeout_in ##1 (!modbus_tcp_in && !selftest_in && !dup_ip_in)
      |=> net_led_out == ($past(phase_w) ? NSL_RED : NSL_OFF);
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout not flashing red"); // R5

   property p_sticky;
      tmo_act_w && !conn_reestab_in |=> tmo_act_w;
   endproperty
   a_sticky: assert property (p_sticky) else $error("timeout cleared early"); // R6

   property p_dup;
      !modbus_tcp_in && !selftest_in && dup_ip_in |=> net_led_out == NSL_RED;
   endproperty
   a_dup: assert property (p_dup) else $error("duplicate address not steady red"); // R7

   property p_test;
      !modbus_tcp_in && selftest_in
      |=> net_led_out == unit_led_out && net_led_out == ($past(phase_w) ? NSL_GREEN : NSL_RED);
   endproperty
   a_test: assert property (p_test) else $error("self-test not alternating"); // R8

   property p_ok;
      !modbus_tcp_in && !selftest_in && !major_fault_in && !minor_w && !unconfigured_in
      |=> unit_led_out == NSL_GREEN;
   endproperty
   a_ok: assert property (p_ok) else $error("operational not steady green"); // R9

   property p_stby;
      !modbus_tcp_in && !selftest_in && !major_fault_in && !minor_w && unconfigured_in
      |=> unit_led_out == ($past(phase_w) ? NSL_GREEN : NSL_OFF);
   endproperty
   a_stby: assert property (p_stby) else $error("standby not flashing green"); // R10

   property p_minor;
      !modbus_tcp_in && !selftest_in && !major_fault_in && (minor_fault_in || config_bad_in)
      |=> unit_led_out == ($past(phase_w) ? NSL_RED : NSL_OFF);
   endproperty
   a_minor: assert property (p_minor) else $error("minor fault not flashing red"); // R11 R12

   property p_major;
      !modbus_tcp_in && !selftest_in && major_fault_in |=> unit_led_out == NSL_RED;
   endproperty
   a_major: assert property (p_major) else $error("major fault not steady red"); // R13 R21

   property p_tcp;
      modbus_tcp_in |=> net_led_out == NSL_OFF && unit_led_out == NSL_OFF;
   endproperty
   a_tcp: assert property (p_tcp) else $error("lamps driven in tcp mode"); // R14

   // enables still hold their reset zeros at the first edge after release
   property p_proto;
      (rtu_en_out & sbus_en_out) == '0 && (!$past(rst_n_in) || (rtu_en_out | sbus_en_out) == '1);
   endproperty
   a_proto: assert property (p_proto) else $error("port protocol overlap"); // R15

   property p_ip_hold;
      ip_loaded_reg |=> active_ip_out == $past(active_ip_out);
   endproperty
   a_ip_hold: assert property (p_ip_hold) else $error("active address changed without power cycle"); // R16

   property p_act;
      coll_w |=> act_led_out == NSL_RED;
   endproperty
   a_act: assert property (p_act) else $error("collision not red"); // R17

   property p_link;
      link_w |=> link_led_out == NSL_GREEN;
   endproperty
   a_link: assert property (p_link) else $error("link lamp not green"); // R18

   property p_dup_over_tmo;
      !modbus_tcp_in && !selftest_in && dup_ip_in && tmo_act_w |=> net_led_out == NSL_RED;
   endproperty
   a_dup_over_tmo: assert property (p_dup_over_tmo) else $error("network priority broken"); // R20

   c_conn: cover property (net_led_out == NSL_GREEN ##1 net_led_out == NSL_GREEN);
   c_tmo_clear: cover property (tmo_act_w ##1 !tmo_act_w);
   c_test: cover property (selftest_in && unit_led_out == NSL_RED ##1 unit_led_out == NSL_GREEN);
   c_coll: cover property (act_led_out == NSL_RED);
   c_half: cover property (flash.half_tick && tmo_act_w);

endmodule // nsl_status_led

// ==== testbench/nsl_lamp_watch.sv ====
`timescale 1ns/1ps
module nsl_lamp_watch (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic clear_in,
   input wire nsl_pkg::nsl_color_type lamp_in,
   output logic [2:0] seen_out
);
   import nsl_pkg::*;
   // ****************************************
   // operator view of one lamp
   // ****************************************
   // {green, red, dark} seen since clear; steady vs flash told apart over a full period
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         seen_out <= 3'h0;
      end else if (clear_in) begin
         seen_out <= 3'h0;
      end else begin
         seen_out <= seen_out | {lamp_in == NSL_GREEN, lamp_in == NSL_RED, lamp_in == NSL_OFF};
      end
   end
endmodule // nsl_lamp_watch

// ==== testbench/nsl_status_led_test.sv ====
`timescale 1ns/1ps
`include "nsl_params.svh"
module nsl_status_led_test;
   import nsl_pkg::*;
   localparam int unsigned HALF = 4;
   localparam int LIMIT = 20000;
   localparam logic [2:0] S_OFF = 3'h1;
   localparam logic [2:0] S_GRN = 3'h4;
   localparam logic [2:0] F_GRN = 3'h5;
   localparam logic [2:0] S_RED = 3'h2;
   localparam logic [2:0] F_RED = 3'h3;
   localparam logic [2:0] ALT = 3'h6;
   logic clk_in, rst_n_in, selftest, tcp, ip_held, conn_open, tmo, reestab, dup;
   logic unconf, minor, cfg_bad, major, act, coll, link, ip_wr, clear;
   logic [`NSL_SERIAL_PORTS-1:0] proto, rtu_en, sbus_en;
   logic [31:0] nv_ip, ip_wr_data, nv_data, active_ip;
   logic nv_wr, pending;
   logic [7:0] lamp_bus;
   logic [2:0] net_seen, unit_seen, act_seen;
   nsl_color_type net_led, unit_led, act_led, link_led;
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;

   nsl_status_led #(.HALF_CYC(HALF)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .selftest_in(selftest),
      .modbus_tcp_in(tcp), .ip_held_in(ip_held), .conn_open_in(conn_open), .conn_timeout_in(tmo),
      .conn_reestab_in(reestab), .dup_ip_in(dup), .unconfigured_in(unconf), .minor_fault_in(minor),
      .config_bad_in(cfg_bad), .major_fault_in(major), .mac_activity_in(act), .mac_collision_in(coll),
      .phy_link_in(link), .port_proto_in(proto), .rtu_en_out(rtu_en), .sbus_en_out(sbus_en),
      .nv_ip_in(nv_ip), .ip_wr_in(ip_wr), .ip_wr_data_in(ip_wr_data), .nv_ip_wr_out(nv_wr),
      .nv_ip_data_out(nv_data), .active_ip_out(active_ip), .ip_change_pending_out(pending),
      .net_led_out(net_led), .unit_led_out(unit_led), .act_led_out(act_led), .link_led_out(link_led),
      .lamp_bus_out(lamp_bus));
   nsl_lamp_watch i_watch_net (.clk_in(clk_in), .rst_n_in(rst_n_in), .clear_in(clear), .lamp_in(net_led),
      .seen_out(net_seen));
   nsl_lamp_watch i_watch_unit (.clk_in(clk_in), .rst_n_in(rst_n_in), .clear_in(clear), .lamp_in(unit_led),
      .seen_out(unit_seen));
   nsl_lamp_watch i_watch_act (.clk_in(clk_in), .rst_n_in(rst_n_in), .clear_in(clear), .lamp_in(act_led),
      .seen_out(act_seen));

   // ****************************************
   // clock, timeout and shared tasks
   // ****************************************
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic do_reset();
      rst_n_in = 1'b0;
      repeat (4) @(negedge clk_in);
      rst_n_in = 1'b1;
      @(negedge clk_in);
   endtask
   task automatic pulse(ref logic sig);
      sig = 1'b1;
      @(negedge clk_in);
      sig = 1'b0;
   endtask
   // settle covers the activity synchroniser; window spans more than a full flash period
   task automatic look(input logic [2:0] e_net, input logic [2:0] e_unit, input logic [2:0] e_act);
      repeat (6) @(negedge clk_in);
      clear = 1'b1;
      @(negedge clk_in);
      clear = 1'b0;
      repeat (2 * HALF + 2) @(negedge clk_in);
      chk(net_seen, e_net);
      chk(unit_seen, e_unit);
      chk(act_seen, e_act);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_net();
      look(S_OFF, S_GRN, S_OFF);
      ip_held = 1'b1;
      look(F_GRN, S_GRN, S_OFF);
      conn_open = 1'b1;
      look(S_GRN, S_GRN, S_OFF);
      dup = 1'b1;
      look(S_RED, S_GRN, S_OFF);
      selftest = 1'b1;
      major = 1'b1;
      look(ALT, ALT, S_OFF);
      {selftest, major, dup} = 3'h0;
   endtask
   task automatic t_timeout();
      tmo = 1'b1;
      repeat (2) @(negedge clk_in);
      tmo = 1'b0;
      look(F_RED, S_GRN, S_OFF);
      pulse(reestab);
      look(F_RED, S_GRN, S_OFF);
      pulse(reestab);
      look(S_GRN, S_GRN, S_OFF);
      pulse(tmo);
      do_reset();
      look(S_GRN, S_GRN, S_OFF);
   endtask
   task automatic t_unit();
      unconf = 1'b1;
      look(S_GRN, F_GRN, S_OFF);
      minor = 1'b1;
      look(S_GRN, F_RED, S_OFF);
      minor = 1'b0;
      cfg_bad = 1'b1;
      look(S_GRN, F_RED, S_OFF);
      major = 1'b1;
      look(S_GRN, S_RED, S_OFF);
      tcp = 1'b1;
      look(S_OFF, S_OFF, S_OFF);
      {tcp, unconf, cfg_bad, major} = 4'h0;
   endtask
   task automatic t_act_link();
      act = 1'b1;
      look(S_GRN, S_GRN, F_GRN);
      coll = 1'b1;
      link = 1'b1;
      dup = 1'b1;
      look(S_RED, S_GRN, S_RED);
      chk(link_led, NSL_GREEN);
      chk(lamp_bus, 8'h99);
      {act, coll, link, dup} = 4'h0;
      repeat (8) @(negedge clk_in);
      chk(link_led, NSL_OFF);
   endtask
   task automatic t_ports();
      for (int p = 0; p < 4; p++) begin
         proto = p[1:0];
         @(negedge clk_in);
         chk(sbus_en, p[1:0]);
         chk(rtu_en, p[1:0] ^ 2'h3);
      end
   endtask
   task automatic t_ip();
      nv_ip = 32'h0A00_0005;
      do_reset();
      chk(active_ip, 32'h0A00_0005);
      chk(pending, 1'b0);
      ip_wr = 1'b1;
      ip_wr_data = 32'h0A00_0063;
      @(negedge clk_in);
      ip_wr_data = 32'h0A00_0077;
      chk({nv_wr, pending}, 2'h3);
      chk(nv_data, 32'h0A00_0063);
      @(negedge clk_in);
      ip_wr = 1'b0;
      chk(nv_data, 32'h0A00_0077);
      chk(active_ip, 32'h0A00_0005);
      @(negedge clk_in);
      chk({nv_wr, pending}, 2'h1);
      // operator cycles power: the store now holds the new address
      nv_ip = nv_data;
      do_reset();
      chk(active_ip, 32'h0A00_0077);
      chk(pending, 1'b0);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rst_n_in = 1'b0;
      {selftest, tcp, ip_held, conn_open, tmo, reestab, dup} = 7'h0;
      {unconf, minor, cfg_bad, major, act, coll, link, ip_wr, clear} = 9'h0;
      proto = '0;
      nv_ip = 32'h0;
      ip_wr_data = 32'h0;
      do_reset();
      t_net();
      t_timeout();
      t_unit();
      t_act_link();
      t_ports();
      t_ip();
      give_verdict();
   end
endmodule // nsl_status_led_test
